// ===== rtl/tcai_pkg.sv
// tcai_pkg: constants and carriers of the carrier alarm integrator
// assumes a 20 MHz core clock and a same-clock line receiver
package tcai_pkg;
  localparam int unsigned CLK_HZ = 32'h0131_2d00; // 20 MHz
  localparam int unsigned MS_PER_S = 32'h0000_03e8;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int unsigned TMR_W = 14;

  // integration times in ms; ranges use one fixed value inside
  localparam logic [13:0] RED_V_DECL_MS = 14'h09c4; // 2500 ms
  localparam logic [13:0] RED_V_RET_MS = 14'h30d4; // 12500 ms
  localparam logic [13:0] DATA_DECL_MS = 14'h01a4; // 420 ms
  localparam logic [13:0] RET_MS = 14'h0054; // 84 ms
  localparam logic [13:0] YEL_D_DECL_MS = 14'h00a8; // 168 ms
  localparam logic [13:0] AIS_V_DECL_MS = 14'h03e8; // 1 s
  localparam logic [13:0] AIS_V_RET_MS = 14'h00a8; // 168 ms
  localparam logic [13:0] AIS_D_DECL_MS = 14'h00fc; // 252 ms

  // register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [11:0] FRA_CNT_OFS = 12'h008;
  localparam logic [11:0] SLIP_CNT_OFS = 12'h00c;
  localparam logic [11:0] FRA_THR_OFS = 12'h010;
  localparam logic [11:0] SLIP_THR_OFS = 12'h014;

  // threshold fields: minor in [7:0], major from bit 16
  localparam int unsigned THR_MAJ_LSB = 16;
  localparam logic [8:0] FRA_MAJ_RST = 9'h1ff;
  localparam logic [7:0] FRA_MIN_RST = 8'h11;
  localparam logic [7:0] SLIP_MAJ_RST = 8'hff;
  localparam logic [7:0] SLIP_MIN_RST = 8'h04;

  typedef enum logic [1:0] {
    TCAI_FMT_D4, TCAI_FMT_ESF, TCAI_FMT_DMX, TCAI_FMT_CELL
  } tcai_fmt_e;

  typedef struct packed {
    logic tag_wide;
    logic tag_split;
    logic tag_active;
    logic bit_oriented_signaling_mode;
    tcai_fmt_e fmt;
    logic voice;
  } tcai_ctrl_s;
  localparam tcai_ctrl_s CTRL_RST = 7'h01;

  typedef struct packed {
    logic oof;
    logic remote_frame_alarm_indication;
    logic ais;
    logic mf_loss;
    logic far_mf_alarm;
    logic realign;
    logic slip;
  } tcai_line_s;

  // hit integration results from the receiver, one-cycle pulses
  typedef struct packed {
    logic red_decl;
    logic red_ret;
    logic yel_decl;
    logic ais_decl;
    logic mfl_decl;
    logic mfl_ret;
    logic rmf_decl;
  } tcai_hit_s;

  typedef struct packed {
    logic yellow_tx;
    logic remote_multiframe_alarm_tx;
    logic trunk_conditioning;
    logic d4_bit2_zero;
    logic fdl_yellow;
    logic data_multiplex_framing_bit6;
  } tcai_act_s;

  typedef struct packed {
    logic slip_major;
    logic slip_minor;
    logic fra_major;
    logic fra_minor;
    logic pm_enable;
    tcai_act_s act;
    logic [4:0] alarm;
  } tcai_stat_s;
endpackage

// ===== rtl/tcai_core.sv
// tcai_core: per-facility carrier alarm integration with APB registers
// assumes line conditions and hit pulses come from same-clock logic
`timescale 1ns/10ps

// Overview of operation
// - voice red: oof 2.5 s or hits
// - voice red retire: 12.5 s clear or hits
// - data red: 420 ms declare, 84 ms retire
// - voice multiframe loss: 2.5 s / 12.5 s
// - data multiframe loss: 420 ms / 84 ms
// - voice yellow: in-frame indication 420 ms
// - data yellow: in-frame indication 168 ms
// - remote multiframe alarm: 420/168, retire 84
// - voice ais: with oof, 1 s or hits
// - voice ais retire 168 ms; ais drop restarts red
// - data ais: 252 ms declare, 84 retire
// - red/ais gate monitoring; reset ber after
// - precedence: red>ais/yellow, yellow>red, ais>yellow
// - d4 yellow forces bit 2 zero
// - esf yellow in data link channel
// - data multiplex yellow in slot 24 bit 6
// - split wide test group suppresses yellow in d4 and cell formats
// - monitor mode or release re-enables yellow
// - multiframe alarms only in bit-oriented signalling
// - count realignments, minor/major thresholds
// - count slips, minor/major thresholds
module tcai_core #(
  parameter int unsigned CYC_PER_MS_P = tcai_pkg::CYC_PER_MS
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire tcai_pkg::tcai_line_s line_in,
  input wire tcai_pkg::tcai_hit_s hit_in,
  output tcai_pkg::tcai_act_s act_out,
  output logic pm_enable_out,
  output logic ber_reset_out
);
  localparam int unsigned N_AL = 5;
  localparam int unsigned IDX_RED = 0;
  localparam int unsigned IDX_YEL = 1;
  localparam int unsigned IDX_AIS = 2;
  localparam int unsigned IDX_MFL = 3;
  localparam int unsigned IDX_RMF = 4;

  tcai_pkg::tcai_ctrl_s ctrl_r;
  logic [8:0] fra_maj_r;
  logic [7:0] fra_min_r, slip_maj_r, slip_min_r;
  logic [15:0] fra_r, slip_r;
  logic [31:0] prdata_r;
  logic [15:0] pre_r;
  logic tick;
  logic [13:0] cnt_r [N_AL];
  logic [13:0] dlim [N_AL];
  logic [13:0] rlim [N_AL];
  logic [13:0] lim [N_AL];
  logic [N_AL-1:0] act_r, act_nxt, dcond, rcond, dhit, rhit;
  logic [N_AL-1:0] run, fire, decl;
  logic ais_d_r, red_restart, voice, bos, in_frame;
  logic carrier_group_alarm, cga_nxt, suppress, is_d4, wr_en, addr_ok;
  tcai_pkg::tcai_act_s act_r_s, act_nxt_s;
  logic pm_r, ber_r;
  logic fra_minor, fra_major, slip_minor, slip_major;
  tcai_pkg::tcai_stat_s stat;
  logic [31:0] rd_mux;

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
  endfunction
  function automatic logic reached(input logic [15:0] c,
                                   input logic [8:0] t);
    reached = (c >= {7'h00, t});
  endfunction
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  assign voice = ctrl_r.voice;
  assign bos = ctrl_r.bit_oriented_signaling_mode;
  assign in_frame = !line_in.oof;
  assign is_d4 = (ctrl_r.fmt == tcai_pkg::TCAI_FMT_D4);
  // yellow held back only while a wide group is split
  assign suppress = ctrl_r.tag_active && ctrl_r.tag_split &&
                    ctrl_r.tag_wide &&
                    (is_d4 || ctrl_r.fmt == tcai_pkg::TCAI_FMT_CELL);

  // ---------------------------------------------------------------
  // millisecond time base
  // ---------------------------------------------------------------
  assign tick = (pre_r == 16'(CYC_PER_MS_P - 1));

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pre_r <= 16'h0000;
    end else if (ce_in) begin
      pre_r <= tick ? 16'h0000 : pre_r + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // qualifying conditions and limits
  // ---------------------------------------------------------------
  always_comb begin
    dcond[IDX_RED] = line_in.oof;
    rcond[IDX_RED] = !line_in.oof;
    dhit[IDX_RED] = hit_in.red_decl;
    rhit[IDX_RED] = voice && hit_in.red_ret;
    dlim[IDX_RED] = voice ? tcai_pkg::RED_V_DECL_MS
                          : tcai_pkg::DATA_DECL_MS;
    rlim[IDX_RED] = voice ? tcai_pkg::RED_V_RET_MS
                          : tcai_pkg::RET_MS;
    dcond[IDX_YEL] = in_frame &&
                     line_in.remote_frame_alarm_indication;
    rcond[IDX_YEL] = !line_in.remote_frame_alarm_indication;
    dhit[IDX_YEL] = voice && hit_in.yel_decl;
    rhit[IDX_YEL] = 1'b0;
    dlim[IDX_YEL] = voice ? tcai_pkg::DATA_DECL_MS
                          : tcai_pkg::YEL_D_DECL_MS;
    rlim[IDX_YEL] = tcai_pkg::RET_MS;
    dcond[IDX_AIS] = line_in.oof && line_in.ais;
    rcond[IDX_AIS] = !line_in.oof && !line_in.ais;
    dhit[IDX_AIS] = hit_in.ais_decl;
    rhit[IDX_AIS] = 1'b0;
    dlim[IDX_AIS] = voice ? tcai_pkg::AIS_V_DECL_MS
                          : tcai_pkg::AIS_D_DECL_MS;
    rlim[IDX_AIS] = voice ? tcai_pkg::AIS_V_RET_MS
                          : tcai_pkg::RET_MS;
    dcond[IDX_MFL] = bos && line_in.mf_loss;
    rcond[IDX_MFL] = !line_in.mf_loss;
    dhit[IDX_MFL] = bos && hit_in.mfl_decl;
    rhit[IDX_MFL] = voice && hit_in.mfl_ret;
    dlim[IDX_MFL] = voice ? tcai_pkg::RED_V_DECL_MS
                          : tcai_pkg::DATA_DECL_MS;
    rlim[IDX_MFL] = voice ? tcai_pkg::RED_V_RET_MS
                          : tcai_pkg::RET_MS;
    dcond[IDX_RMF] = bos && in_frame && line_in.far_mf_alarm;
    rcond[IDX_RMF] = !line_in.far_mf_alarm;
    dhit[IDX_RMF] = bos && voice && hit_in.rmf_decl;
    rhit[IDX_RMF] = 1'b0;
    dlim[IDX_RMF] = voice ? tcai_pkg::DATA_DECL_MS
                          : tcai_pkg::YEL_D_DECL_MS;
    rlim[IDX_RMF] = tcai_pkg::RET_MS;
  end

  // ais dropping under a persisting oof restarts red timing
  assign red_restart = act_r[IDX_AIS] && line_in.oof &&
                       ais_d_r && !line_in.ais;

  always_comb begin
    for (int i = 0; i < N_AL; i++) begin
      lim[i] = act_r[i] ? rlim[i] : dlim[i];
      run[i] = act_r[i] ? rcond[i] : dcond[i];
      fire[i] = (act_r[i] ? rhit[i] : dhit[i]) ||
                (run[i] && tick && cnt_r[i] == lim[i] - 14'h0001);
      decl[i] = fire[i] && !act_r[i];
    end
  end

  // ---------------------------------------------------------------
  // integration timers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < N_AL; i++) begin
        cnt_r[i] <= 14'h0000;
      end
      ais_d_r <= 1'b0;
    end else if (ce_in) begin
      ais_d_r <= line_in.ais;
      for (int i = 0; i < N_AL; i++) begin
        if (!run[i] || fire[i]) begin
          cnt_r[i] <= 14'h0000;
        end else if (i == IDX_RED && red_restart) begin
          cnt_r[i] <= 14'h0000;
        end else if (tick) begin
          cnt_r[i] <= cnt_r[i] + 14'h0001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // alarm states with precedence
  // ---------------------------------------------------------------
  always_comb begin
    act_nxt = act_r ^ fire;
    if (decl[IDX_RED]) begin
      act_nxt[IDX_AIS] = 1'b0;
      act_nxt[IDX_YEL] = 1'b0;
    end
    if (decl[IDX_YEL]) begin
      act_nxt[IDX_RED] = 1'b0;
    end
    if (decl[IDX_AIS]) begin
      act_nxt[IDX_YEL] = 1'b0;
    end
    if (!bos) begin
      act_nxt[IDX_MFL] = 1'b0;
      act_nxt[IDX_RMF] = 1'b0;
    end
  end

  assign carrier_group_alarm = act_r[IDX_RED] || act_r[IDX_AIS];
  assign cga_nxt = act_nxt[IDX_RED] || act_nxt[IDX_AIS];

  always_comb begin
    act_nxt_s.yellow_tx = cga_nxt && !suppress;
    act_nxt_s.remote_multiframe_alarm_tx = act_nxt[IDX_MFL];
    act_nxt_s.trunk_conditioning = cga_nxt || act_nxt[IDX_YEL] ||
                                   act_nxt[IDX_RMF];
    act_nxt_s.d4_bit2_zero = act_nxt_s.yellow_tx && is_d4;
    act_nxt_s.fdl_yellow = act_nxt_s.yellow_tx &&
                           ctrl_r.fmt == tcai_pkg::TCAI_FMT_ESF;
    act_nxt_s.data_multiplex_framing_bit6 = act_nxt_s.yellow_tx &&
      ctrl_r.fmt == tcai_pkg::TCAI_FMT_DMX;
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      act_r <= '0;
    end else if (ce_in) begin
      act_r <= act_nxt;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      act_r_s <= '0;
      pm_r <= 1'b1;
      ber_r <= 1'b0;
    end else if (ce_in) begin
      act_r_s <= act_nxt_s;
      pm_r <= !cga_nxt;
      ber_r <= carrier_group_alarm && !cga_nxt;
    end
  end

  assign act_out = act_r_s;
  assign pm_enable_out = pm_r;
  assign ber_reset_out = ber_r;

  // ---------------------------------------------------------------
  // realignment and slip counters
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      fra_r <= 16'h0000;
    end else if (ce_in) begin
      if (wr_en && paddr_in == tcai_pkg::FRA_CNT_OFS) begin
        fra_r <= {15'h0000, line_in.realign && !carrier_group_alarm};
      end else if (line_in.realign && !carrier_group_alarm) begin
        fra_r <= sat_inc(fra_r);
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      slip_r <= 16'h0000;
    end else if (ce_in) begin
      if (wr_en && paddr_in == tcai_pkg::SLIP_CNT_OFS) begin
        slip_r <= {15'h0000, line_in.slip && !carrier_group_alarm};
      end else if (line_in.slip && !carrier_group_alarm) begin
        slip_r <= sat_inc(slip_r);
      end
    end
  end

  assign fra_minor = reached(fra_r, {1'b0, fra_min_r});
  assign fra_major = reached(fra_r, fra_maj_r);
  assign slip_minor = reached(slip_r, {1'b0, slip_min_r});
  assign slip_major = reached(slip_r, {1'b0, slip_maj_r});

  // ---------------------------------------------------------------
  // apb slave, zero wait states while enabled
  // ---------------------------------------------------------------
  assign pready_out = ce_in;
  assign wr_en = ce_in && psel_in && penable_in && pwrite_in;
  assign addr_ok = paddr_in <= tcai_pkg::SLIP_THR_OFS &&
                   paddr_in[1:0] == 2'h0;
  assign pslverr_out = psel_in && penable_in && !addr_ok;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ctrl_r <= tcai_pkg::CTRL_RST;
      fra_maj_r <= tcai_pkg::FRA_MAJ_RST;
      fra_min_r <= tcai_pkg::FRA_MIN_RST;
      slip_maj_r <= tcai_pkg::SLIP_MAJ_RST;
      slip_min_r <= tcai_pkg::SLIP_MIN_RST;
    end else if (wr_en) begin
      case (paddr_in)
        tcai_pkg::CTRL_OFS: begin
          ctrl_r <= pwdata_in[6:0];
        end
        tcai_pkg::FRA_THR_OFS: begin
          fra_min_r <= pwdata_in[7:0];
          fra_maj_r <= pwdata_in[tcai_pkg::THR_MAJ_LSB +: 9];
        end
        tcai_pkg::SLIP_THR_OFS: begin
          slip_min_r <= pwdata_in[7:0];
          slip_maj_r <= pwdata_in[tcai_pkg::THR_MAJ_LSB +: 8];
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    stat = {slip_major, slip_minor, fra_major, fra_minor, pm_r,
            act_r_s, act_r};
    case (paddr_in)
      tcai_pkg::CTRL_OFS: rd_mux = {25'h0000000, ctrl_r};
      tcai_pkg::STAT_OFS: rd_mux = 32'(stat);
      tcai_pkg::FRA_CNT_OFS: rd_mux = {16'h0000, fra_r};
      tcai_pkg::SLIP_CNT_OFS: rd_mux = {16'h0000, slip_r};
      tcai_pkg::FRA_THR_OFS: rd_mux = {7'h00, fra_maj_r, 8'h00,
                                       fra_min_r};
      tcai_pkg::SLIP_THR_OFS: rd_mux = {8'h00, slip_maj_r, 8'h00,
                                        slip_min_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      prdata_r <= 32'h0000_0000;
    end else if (ce_in && psel_in && !penable_in) begin
      prdata_r <= rd_mux;
    end
  end

  assign prdata_out = prdata_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_red_v_due;
    ce_in && tick && voice && !act_r[IDX_RED] && run[IDX_RED] &&
    cnt_r[IDX_RED] == tcai_pkg::RED_V_DECL_MS - 14'h0001;
  endsequence
  sequence s_red_d_due;
    ce_in && tick && !voice && !act_r[IDX_RED] && run[IDX_RED] &&
    cnt_r[IDX_RED] == tcai_pkg::DATA_DECL_MS - 14'h0001;
  endsequence
  sequence s_cga_clear;
    $fell(carrier_group_alarm);
  endsequence
  chk_red_voice_decl: assert property (
    s_red_v_due |=> act_r[IDX_RED] && act_out.trunk_conditioning)
    else $error("voice red not declared at 2500 ms");
  chk_red_data_decl: assert property (
    s_red_d_due |=> act_r[IDX_RED])
    else $error("data red not declared at 420 ms");
  chk_red_retire: assert property (
    ce_in && tick && voice && act_r[IDX_RED] && !line_in.oof &&
    cnt_r[IDX_RED] == tcai_pkg::RED_V_RET_MS - 14'h0001
    |=> !act_r[IDX_RED])
    else $error("voice red not retired at 12500 ms");
  chk_timer_restart: assert property (
    ce_in && !run[IDX_YEL] |=> cnt_r[IDX_YEL] == 14'h0000)
    else $error("yellow timer not restarted");
  chk_pm_gate: assert property (
    carrier_group_alarm |-> !pm_enable_out)
    else $error("monitoring active during red or ais");
  chk_ber_reset: assert property (
    s_cga_clear |-> ber_reset_out ##1 (!ber_reset_out || !ce_in))
    else $error("ber reset missing after alarm clear");
  chk_yel_suppress: assert property (
    ce_in && suppress |=> !act_out.yellow_tx)
    else $error("yellow sent while test group split");
  chk_d4_bit2: assert property (
    act_out.d4_bit2_zero |-> act_out.yellow_tx && carrier_group_alarm)
    else $error("bit 2 forced without yellow");
  chk_bos_gate: assert property (
    ce_in && !bos |=> !act_r[IDX_MFL] && !act_r[IDX_RMF])
    else $error("multiframe alarm outside bos mode");
  chk_fra_minor: assert property (
    ce_in && line_in.realign && !wr_en && !carrier_group_alarm &&
    fra_r == {8'h00, fra_min_r} - 16'h0001 |=> fra_minor)
    else $error("realign minor not raised at threshold");
  chk_slip_major: assert property (
    ce_in && line_in.slip && !wr_en && !carrier_group_alarm &&
    slip_r == {8'h00, slip_maj_r} - 16'h0001 |=> slip_major)
    else $error("slip major not raised at threshold");
endmodule // tcai_core

// ===== tb/tcai_far_end.sv
// tcai_far_end: far-end carrier terminal as seen by the line receiver
// assumes the bench commands conditions; all outputs are same-clock
`timescale 1ns/10ps
module tcai_far_end (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [4:0] cond_in,
  input wire logic [1:0] ev_in,
  input wire tcai_pkg::tcai_hit_s hit_in,
  output tcai_pkg::tcai_line_s line_out,
  output tcai_pkg::tcai_hit_s hit_out
);
  // ----------------------------------------
  // line conditions, registered like a receiver
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      line_out <= '0;
      hit_out <= '0;
    end else begin
      line_out <= {cond_in, ev_in};
      hit_out <= hit_in;
    end
  end
endmodule // tcai_far_end

// ===== tb/t1_carrier_alarm_integrator_tb.sv
// t1_carrier_alarm_integrator_tb: self-checking bench for tcai_core
// assumes tcai_pkg and tcai_far_end are compiled first
`timescale 1ns/10ps
module t1_carrier_alarm_integrator_tb;
  localparam int CPM = 4;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [4:0] cond = '0;
  logic [1:0] ev = '0;
  tcai_pkg::tcai_hit_s hit = '0;
  tcai_pkg::tcai_hit_s hit_l;
  tcai_pkg::tcai_line_s line;
  tcai_pkg::tcai_act_s act;
  logic pm;
  logic ber;
  int err_total = 0;
  int total_checks = 0;
  int ber_cnt = 0;
  logic [31:0] q;
  logic e;

  always #25 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) if (ber === 1'b1) ber_cnt++;

  tcai_core #(.CYC_PER_MS_P(CPM)) u_tcai_core (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .line_in(line),
    .hit_in(hit_l), .act_out(act), .pm_enable_out(pm),
    .ber_reset_out(ber)
  );
  tcai_far_end u_tcai_far_end (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .cond_in(cond),
    .ev_in(ev), .hit_in(hit), .line_out(line), .hit_out(hit_l)
  );

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask
  task wrap_up;
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_in);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      wrap_up;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    // idle edge keeps back-to-back drives apart
    @(posedge core_clk_in);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, x, q);
  endtask
  task ms(input int n);
    repeat (n * CPM) @(posedge core_clk_in);
  endtask
  task hp(input logic [6:0] h);
    hit <= h;
    @(posedge core_clk_in);
    hit <= '0;
  endtask
  // trunk, upstream yellow, monitoring
  task st(input logic [2:0] x, input string nm);
    chk(nm, {29'h0, x}, {29'h0, act.trunk_conditioning, act.yellow_tx, pm});
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    rd(tcai_pkg::CTRL_OFS, 32'h0000_0001, "ctrl");
    rd(tcai_pkg::FRA_THR_OFS, 32'h01ff_0011, "fra_thr");
    rd(tcai_pkg::SLIP_THR_OFS, 32'h00ff_0004, "slip_thr");
    wr(tcai_pkg::STAT_OFS, 32'hffff_ffff);
    rd(tcai_pkg::STAT_OFS, 32'h0000_0800, "stat");
    apb(1'b0, 12'h018, 32'h0000_0000);
    chk("slverr", 32'h1, {31'h0, e});
    chk("unmapped", 32'h0, q);
    // voice red on timer, retired by hits
    cond <= 5'h10;
    ms(2497);
    st(3'b001, "red_pre");
    ms(5);
    st(3'b110, "red_voice");
    chk("bit2", 32'h1, {31'h0, act.d4_bit2_zero});
    cond <= '0;
    hp(7'h20);
    ms(1);
    st(3'b001, "red_ret");
    // data red, interrupted integration restarts
    wr(tcai_pkg::CTRL_OFS, 32'h0000_0002);
    cond <= 5'h10;
    ms(300);
    cond <= '0;
    ms(1);
    cond <= 5'h10;
    ms(418);
    st(3'b001, "red_restart");
    ms(5);
    st(3'b110, "red_data");
    chk("fdl", 32'h1, {31'h0, act.fdl_yellow});
    cond <= '0;
    ms(82);
    st(3'b110, "red_hold");
    ms(4);
    st(3'b001, "red_clear");
    chk("ber", 32'h2, ber_cnt);
    // data-multiplex red by hit
    wr(tcai_pkg::CTRL_OFS, 32'h0000_0004);
    hp(7'h40);
    ms(1);
    st(3'b110, "hit_red");
    chk("bit6", 32'h1, {31'h0, act.data_multiplex_framing_bit6});
    // a slip under red must not be counted
    ev <= 2'b01;
    @(posedge core_clk_in);
    ev <= 2'b00;
    ms(86);
    st(3'b001, "dmx_clear");
    // wide split test group blocks upstream yellow
    wr(tcai_pkg::CTRL_OFS, 32'h0000_0071);
    hp(7'h40);
    ms(1);
    st(3'b100, "suppressed");
    wr(tcai_pkg::CTRL_OFS, 32'h0000_0051);
    ms(1);
    st(3'b110, "monitor");
    wr(tcai_pkg::CTRL_OFS, 32'h0000_0071);
    ms(1);
    st(3'b100, "resplit");
    wr(tcai_pkg::CTRL_OFS, 32'h0000_0061);
    ms(1);
    st(3'b110, "released");
    hp(7'h10);
    ms(1);
    st(3'b101, "yel_over_red");
    ms(86);
    st(3'b001, "yel_ret");
    // data yellow keeps monitoring alive
    wr(tcai_pkg::CTRL_OFS, 32'h0000_0002);
    cond <= 5'h08;
    ms(166);
    st(3'b001, "yel_pre");
    ms(4);
    st(3'b101, "yel_data");
    cond <= '0;
    ms(86);
    st(3'b001, "yel_clear");
    // data ais, held while out-of-frame remains
    cond <= 5'h14;
    ms(250);
    st(3'b001, "ais_pre");
    ms(4);
    st(3'b110, "ais_data");
    cond <= 5'h10;
    ms(90);
    st(3'b110, "ais_hold");
    cond <= '0;
    ms(86);
    st(3'b001, "ais_clear");
    // voice ais on timer
    wr(tcai_pkg::CTRL_OFS, 32'h0000_0001);
    cond <= 5'h14;
    ms(998);
    st(3'b001, "ais_v_pre");
    ms(4);
    st(3'b110, "ais_voice");
    cond <= '0;
    ms(166);
    st(3'b110, "ais_v_hold");
    ms(4);
    st(3'b001, "ais_v_clear");
    // multiframe loss in bit-oriented data mode
    wr(tcai_pkg::CTRL_OFS, 32'h0000_000a);
    cond <= 5'h02;
    ms(418);
    chk("rma_pre", 32'h0, {31'h0, act.remote_multiframe_alarm_tx});
    ms(5);
    chk("rma_tx", 32'h1, {31'h0, act.remote_multiframe_alarm_tx});
    wr(tcai_pkg::CTRL_OFS, 32'h0000_0002);
    ms(1);
    chk("rma_off", 32'h0, {31'h0, act.remote_multiframe_alarm_tx});
    cond <= '0;
    // voice multiframe loss by hits, then data remote alarm
    wr(tcai_pkg::CTRL_OFS, 32'h0000_0009);
    hp(7'h04);
    ms(1);
    chk("rma_hit", 32'h1, {31'h0, act.remote_multiframe_alarm_tx});
    hp(7'h02);
    ms(1);
    chk("rma_hoff", 32'h0, {31'h0, act.remote_multiframe_alarm_tx});
    wr(tcai_pkg::CTRL_OFS, 32'h0000_000a);
    cond <= 5'h01;
    ms(166);
    st(3'b001, "rmf_pre");
    ms(4);
    st(3'b101, "rmf_data");
    cond <= '0;
    ms(86);
    st(3'b001, "rmf_clear");
    // event counters against thresholds
    wr(tcai_pkg::FRA_THR_OFS, 32'h0003_0002);
    wr(tcai_pkg::SLIP_THR_OFS, 32'h0002_0001);
    ev <= 2'b11;
    @(posedge core_clk_in);
    ev <= 2'b10;
    @(posedge core_clk_in);
    ev <= 2'b00;
    ms(1);
    apb(1'b0, tcai_pkg::STAT_OFS, 32'h0000_0000);
    chk("exc_minor", 32'h5, {28'h0, q[15:12]});
    ev <= 2'b11;
    @(posedge core_clk_in);
    ev <= 2'b00;
    ms(1);
    apb(1'b0, tcai_pkg::STAT_OFS, 32'h0000_0000);
    chk("exc_major", 32'hf, {28'h0, q[15:12]});
    rd(tcai_pkg::FRA_CNT_OFS, 32'h0000_0003, "fra_cnt");
    rd(tcai_pkg::SLIP_CNT_OFS, 32'h0000_0002, "slip_cnt");
    wr(tcai_pkg::FRA_CNT_OFS, 32'h0000_0000);
    rd(tcai_pkg::FRA_CNT_OFS, 32'h0000_0000, "fra_clr");
    wrap_up;
  end
endmodule // t1_carrier_alarm_integrator_tb
